// ---- design/ibh_map.vh ----
// Register map, field positions, reset values and timing counts
// for the ISA DMA bus handoff and status block.
// Assumes an 8-bit register port addressed by a 16-bit address.
`ifndef IBH_MAP_VH
`define IBH_MAP_VH

// Register offsets
`define IBH_OFS_HANDOFF      16'h7F70
`define IBH_OFS_MIRROR       16'h7F73
`define IBH_OFS_MASK         16'h7F74
`define IBH_OFS_IRQ_STAT     16'h7F75

// Bus handoff register fields
`define IBH_TCSUP_HI         7
`define IBH_TCSUP_LO         4
`define IBH_DMA_RST_BIT      3
`define IBH_AEN_BIT          2
`define IBH_GRANT_BIT        1
`define IBH_HOLD_BIT         0

// Status mirror fields
`define IBH_REQ_HI           7
`define IBH_REQ_LO           4
`define IBH_DONE_HI          3
`define IBH_DONE_LO          0

// Interrupt status register fields
`define IBH_IRQ_FLAG_BIT     0
`define IBH_DRAIN_BIT        1

// Reset values
`define IBH_RST_HANDOFF      8'h00
`define IBH_RST_MASK         8'hFF
`define IBH_RST_DATA         8'h00

// Drain time after grant removal, in ns, and clock rate in MHz
`define IBH_DRAIN_NS         1500
`define IBH_CLK_MHZ          20
// Least time, rounded up to whole cycles
`define IBH_DRAIN_CYC        ((`IBH_DRAIN_NS * `IBH_CLK_MHZ + 999) / 1000)

`endif

// ---- design/ibh_sync.v ----
// Two-flop synchroniser for a bundle of independent levels.
// Assumes each bit is a slow level from another clock domain.
`timescale 1ns/100ps
module ibh_sync #(
    parameter W = 8
) (
    input  wire         clk_i,   // Sampling clock
    input  wire         rst_i,   // Synchronous reset, high
    input  wire [W-1:0] d_i,     // Asynchronous levels
    output wire [W-1:0] q_o      // Synchronised levels
);

reg [W-1:0] meta_ff;
reg [W-1:0] sync_ff;

// First stage feeds only the second stage
always @(posedge clk_i) begin
    if (rst_i) begin
        meta_ff <= {W{1'b0}};
        sync_ff <= {W{1'b0}};
    end else begin
        meta_ff <= d_i;
        sync_ff <= meta_ff;
    end
end

assign q_o = sync_ff;

endmodule

// ---- design/ibh_top.v ----
// ISA DMA bus handoff, status mirror and DMA interrupt logic.
// Holds the handoff, mirror, mask and interrupt flag registers;
// the controller's own registers sit behind the ISA window.
// Assumes the DMA controller runs on its own clock; all of its
// outputs are synchronised here before use. Register port is a
// plain strobe port with read data one cycle after the strobe.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/100ps
`include "ibh_map.vh"

// What this block does
// - Handoff bits 7..4 suppress channel terminal count
// - Memory-to-memory cycles ignore suppression bits
// - Handoff bit 3 holds DMA controller reset
// - Bit 2 shows live address enable, no interrupt
// - Bit 1 grant tri-states shared microcontroller drivers
// - Bit 0 shows live hold request, no interrupt
// - Mirror bits 7..4 show pending channel requests
// - Mirror bits 3..0 show terminal count reached
// - Mirror continuously follows controller channel status
// - Mirror follows controller clearing done bits
// - Reading the mirror has no side effect
// - Enabled mirror rising edge latches DMA interrupt
// - Mask bit 1 blocks, reset all masked
// - Mirror readable anytime without owning the bus
module ibh_top #(
    parameter NCH = 4,              // DMA channels
    parameter DRAIN_CYC = `IBH_DRAIN_CYC  // Drain wait, cycles
) (
    input  wire        CLOCK_I,          // 20 MHz clock
    input  wire        RESET_I,          // Synchronous reset, high
    input  wire [15:0] REG_ADDR_I,       // Register address
    input  wire [7:0]  REG_WDATA_I,      // Register write data
    input  wire        REG_WR_I,         // Write strobe
    input  wire        REG_RD_I,         // Read strobe
    output wire [7:0]  REG_RDATA_O,      // Read data, next cycle
    input  wire        DMA_HOLD_REQ_I,   // Controller hold request
    input  wire        DMA_AEN_I,        // Controller address enable
    input  wire [7:0]  DMA_CH_STATUS_I,  // Controller channel status
    input  wire [3:0]  DMA_TC_I,         // Per-channel terminal count
    input  wire        DMA_MEM2MEM_I,    // Memory-to-memory cycle
    output wire        DMA_RESET_O,      // Controller reset, high
    output wire        BUS_GRANT_ACK_O,  // Bus grant to controller
    output wire        MCU_ISA_DRV_EN_O, // Shared driver enable
    output wire        ISA_EOP_N_O,      // End of process, low
    output wire        DMA_IRQ_O,        // DMA interrupt flag
    output wire        DRAIN_BUSY_O      // Transfer drain in progress
);

// Width of the bundle crossing from the controller clock
localparam SYNC_W = 15;

// Synchronised controller signals
wire [SYNC_W-1:0] sync_in;
wire [SYNC_W-1:0] sync_out;
wire              hold_sync;
wire              aen_sync;
wire [7:0]        status_sync;
wire [3:0]        tc_sync;
wire              m2m_sync;

// Handoff register fields
reg  [3:0]        tc_suppress_ff;
reg  [3:0]        nxt_tc_suppress;
reg               dma_reset_ff;
reg               nxt_dma_reset;
reg               bus_grant_ack_ff;
reg               nxt_bus_grant_ack;
reg               drv_en_ff;

// Mask and edge detect state
reg  [7:0]        irq_block_ff;
reg  [7:0]        nxt_irq_block;
reg  [7:0]        mirror_prev_ff;
wire [7:0]        mirror_rise;
wire              irq_event;

// Interrupt flag
reg               irq_flag_ff;
reg               nxt_irq_flag;

// Drain timer after grant removal
reg  [7:0]        drain_cnt_ff;
reg  [7:0]        nxt_drain_cnt;
reg               drain_busy_ff;

// End of process output
reg               eop_n_ff;
wire [3:0]        tc_pass;
wire              eop_active;

// Register port
wire              hit_handoff;
wire              hit_mirror;
wire              hit_mask;
wire              hit_irq;
wire              wr_handoff;
wire              wr_mask;
wire              wr_irq;
reg  [7:0]        read_mux;
reg  [7:0]        rdata_ff;

// Mirror fields as seen by software
wire [3:0]        req_pending;
wire [3:0]        count_done;

// Constants widened to full width, cut by part-select where used
wire [7:0]        rst_handoff;
wire [31:0]       drain_load;

// Bundle controller outputs for synchronisation
assign sync_in = {DMA_MEM2MEM_I, DMA_TC_I, DMA_CH_STATUS_I,
                  DMA_AEN_I, DMA_HOLD_REQ_I};

// Two flops on every controller signal. The bits are independent
// levels, so one bit may land a cycle before its neighbour; the
// outputs built from them settle one cycle later at the most.
ibh_sync #(
    .W (SYNC_W)
) u_sync (
    .clk_i (CLOCK_I),
    .rst_i (RESET_I),
    .d_i   (sync_in),
    .q_o   (sync_out)
);

// Unpack synchronised bundle
assign hold_sync   = sync_out[0];
assign aen_sync    = sync_out[1];
assign status_sync = sync_out[9:2];
assign tc_sync     = sync_out[13:10];
assign m2m_sync    = sync_out[14];

// Request nibble over done nibble; the controller clears the done
// nibble on its own status read, and the mirror follows two cycles on
assign req_pending = status_sync[`IBH_REQ_HI:`IBH_REQ_LO];
assign count_done  = status_sync[`IBH_DONE_HI:`IBH_DONE_LO];

// Reset image and drain load value
assign rst_handoff = `IBH_RST_HANDOFF;
assign drain_load  = DRAIN_CYC;

// Address decode, exact 16-bit match
// Unmapped addresses hit nothing, so writes to them are dropped
assign hit_handoff = (REG_ADDR_I == `IBH_OFS_HANDOFF);
assign hit_mirror  = (REG_ADDR_I == `IBH_OFS_MIRROR);
assign hit_mask    = (REG_ADDR_I == `IBH_OFS_MASK);
assign hit_irq     = (REG_ADDR_I == `IBH_OFS_IRQ_STAT);

// Write qualifiers; the mirror takes no writes
assign wr_handoff  = REG_WR_I & hit_handoff;
assign wr_mask     = REG_WR_I & hit_mask;
assign wr_irq      = REG_WR_I & hit_irq;

// Next value of handoff register writable fields
// Address enable and hold bits are read-only and ignore writes
always @* begin
    nxt_tc_suppress   = tc_suppress_ff;
    nxt_dma_reset     = dma_reset_ff;
    nxt_bus_grant_ack = bus_grant_ack_ff;
    if (wr_handoff) begin
        nxt_tc_suppress   =
            REG_WDATA_I[`IBH_TCSUP_HI:`IBH_TCSUP_LO];
        nxt_dma_reset     = REG_WDATA_I[`IBH_DMA_RST_BIT];
        nxt_bus_grant_ack = REG_WDATA_I[`IBH_GRANT_BIT];
    end
end

// Handoff register flops
always @(posedge CLOCK_I) begin
    if (RESET_I) begin
        tc_suppress_ff   <= rst_handoff[`IBH_TCSUP_HI:`IBH_TCSUP_LO];
        dma_reset_ff     <= rst_handoff[`IBH_DMA_RST_BIT];
        bus_grant_ack_ff <= rst_handoff[`IBH_GRANT_BIT];
    end else begin
        tc_suppress_ff   <= nxt_tc_suppress;
        dma_reset_ff     <= nxt_dma_reset;
        bus_grant_ack_ff <= nxt_bus_grant_ack;
    end
end

// Shared drivers off in the same cycle the grant rises; the enable
// comes from the next grant, so the two flops never overlap
always @(posedge CLOCK_I) begin
    if (RESET_I) begin
        drv_en_ff <= 1'b1;
    end else begin
        drv_en_ff <= ~nxt_bus_grant_ack;
    end
end

// Drain timer loads on grant removal, counts down to zero.
// The count is a fixed worst case; software must keep off the
// shared bus until the busy flag has fallen.
always @* begin
    nxt_drain_cnt = drain_cnt_ff;
    if (bus_grant_ack_ff & ~nxt_bus_grant_ack) begin
        nxt_drain_cnt = drain_load[7:0];
    end else if (nxt_bus_grant_ack) begin
        nxt_drain_cnt = 8'h00;
    end else if (drain_cnt_ff != 8'h00) begin
        nxt_drain_cnt = drain_cnt_ff - 8'h01;
    end
end

// Drain timer and busy flag
always @(posedge CLOCK_I) begin
    if (RESET_I) begin
        drain_cnt_ff  <= 8'h00;
        drain_busy_ff <= 1'b0;
    end else begin
        drain_cnt_ff  <= nxt_drain_cnt;
        drain_busy_ff <= (nxt_drain_cnt != 8'h00);
    end
end

// Per-channel terminal count gating
genvar ch;
generate
    for (ch = 0; ch < NCH; ch = ch + 1) begin : g_tc
        // Suppression applies outside memory-to-memory cycles only
        assign tc_pass[ch] = tc_sync[ch] &
                             (~tc_suppress_ff[ch] | m2m_sync);
    end
endgenerate

// Memory-to-memory cycles keep normal end of process
assign eop_active = |tc_pass;

// End of process output flop, active low
// A suppressed channel pulls the line low only in memory-to-memory cycles
always @(posedge CLOCK_I) begin
    if (RESET_I) begin
        eop_n_ff <= 1'b1;
    end else begin
        eop_n_ff <= ~eop_active;
    end
end

// Mask register, reset fully masked
// so no edge interrupts before software opts in
always @* begin
    nxt_irq_block = irq_block_ff;
    if (wr_mask) begin
        nxt_irq_block = REG_WDATA_I;
    end
end

// Mask register flops
always @(posedge CLOCK_I) begin
    if (RESET_I) begin
        irq_block_ff <= `IBH_RST_MASK;
    end else begin
        irq_block_ff <= nxt_irq_block;
    end
end

// Previous-cycle copy of the synchronised mirror
// Registered on the same clock as the comparison below
always @(posedge CLOCK_I) begin
    if (RESET_I) begin
        mirror_prev_ff <= `IBH_RST_DATA;
    end else begin
        mirror_prev_ff <= status_sync;
    end
end

// Enabled low-to-high transitions; hold and address enable excluded
// Both copies reset to zero, so no false edge follows reset
assign mirror_rise = status_sync & ~mirror_prev_ff;
assign irq_event   = |(mirror_rise & ~irq_block_ff);

// Sticky flag: set beats a write-one clear, so an edge that
// arrives in the clearing cycle is never lost
always @* begin
    nxt_irq_flag = irq_flag_ff;
    if (wr_irq & REG_WDATA_I[`IBH_IRQ_FLAG_BIT]) begin
        nxt_irq_flag = 1'b0;
    end
    if (irq_event) begin
        nxt_irq_flag = 1'b1;
    end
end

// Interrupt flag flop
always @(posedge CLOCK_I) begin
    if (RESET_I) begin
        irq_flag_ff <= 1'b0;
    end else begin
        irq_flag_ff <= nxt_irq_flag;
    end
end

// Read data selection; unmapped addresses read zero
always @* begin
    read_mux = `IBH_RST_DATA;
    if (hit_handoff) begin
        read_mux[`IBH_TCSUP_HI:`IBH_TCSUP_LO] = tc_suppress_ff;
        read_mux[`IBH_DMA_RST_BIT] = dma_reset_ff;
        read_mux[`IBH_AEN_BIT]     = aen_sync;
        read_mux[`IBH_GRANT_BIT]   = bus_grant_ack_ff;
        read_mux[`IBH_HOLD_BIT]    = hold_sync;
    end else if (hit_mirror) begin
        // Live view, no bus ownership, no side effect
        read_mux = {req_pending, count_done};
    end else if (hit_mask) begin
        read_mux = irq_block_ff;
    end else if (hit_irq) begin
        read_mux[`IBH_IRQ_FLAG_BIT] = irq_flag_ff;
        read_mux[`IBH_DRAIN_BIT]    = drain_busy_ff;
    end
end

// The mirror is a plain view of the synchronised status: a read
// strobe only copies it into the read data flop, so no mirror bit
// is cleared or changed by software. Done bits fall only when the
// controller itself clears them, and the mirror then follows.

// Read data stands only in the cycle after the strobe
// and returns to zero so stale data never lingers
always @(posedge CLOCK_I) begin
    if (RESET_I) begin
        rdata_ff <= `IBH_RST_DATA;
    end else if (REG_RD_I) begin
        rdata_ff <= read_mux;
    end else begin
        rdata_ff <= `IBH_RST_DATA;
    end
end

// Outputs straight from flops
assign REG_RDATA_O      = rdata_ff;
assign DMA_RESET_O      = dma_reset_ff;
assign BUS_GRANT_ACK_O  = bus_grant_ack_ff;
assign MCU_ISA_DRV_EN_O = drv_en_ff;
assign ISA_EOP_N_O      = eop_n_ff;
assign DMA_IRQ_O        = irq_flag_ff;
assign DRAIN_BUSY_O     = drain_busy_ff;

endmodule

// ---- dv/ibh_top_asserts.sv ----
// Port checks for the DMA bus handoff block.
// Assumes one clock and a synchronous high reset.
`timescale 1ns/100ps
module ibh_top_asserts #(
    parameter int DRAIN_CYC = 30  // Drain wait, cycles
) (
    input logic        CLOCK_I,          // Clock
    input logic        RESET_I,          // Reset
    input logic [15:0] REG_ADDR_I,       // Address
    input logic [7:0]  REG_WDATA_I,      // Write data
    input logic        REG_WR_I,         // Write strobe
    input logic        REG_RD_I,         // Read strobe
    input logic [7:0]  REG_RDATA_O,      // Read data
    input logic [7:0]  DMA_CH_STATUS_I,  // Channel status
    input logic [3:0]  DMA_TC_I,         // Terminal counts
    input logic        DMA_MEM2MEM_I,    // Mem-to-mem cycle
    input logic        DMA_RESET_O,      // Controller reset
    input logic        BUS_GRANT_ACK_O,  // Bus grant
    input logic        MCU_ISA_DRV_EN_O, // Driver enable
    input logic        ISA_EOP_N_O,      // End of process
    input logic        DMA_IRQ_O,        // Interrupt flag
    input logic        DRAIN_BUSY_O      // Drain busy
);
    localparam int DMAX = DRAIN_CYC + 2;  // Longest drain
    // All checks on the one clock
    default clocking @(posedge CLOCK_I);
    endclocking
    default disable iff (RESET_I);
    dma_rst_a: assert property (
        REG_WR_I && REG_ADDR_I == 16'h7F70
        |=> DMA_RESET_O == $past(REG_WDATA_I[3]))
        else $error("controller reset differs from write");
    grant_a: assert property (
        REG_WR_I && REG_ADDR_I == 16'h7F70
        |=> BUS_GRANT_ACK_O == $past(REG_WDATA_I[1]))
        else $error("grant differs from write");
    drv_en_a: assert property (
        MCU_ISA_DRV_EN_O != BUS_GRANT_ACK_O)
        else $error("drivers on while granted");
    irq_hold_a: assert property (
        DMA_IRQ_O && !(REG_WR_I && REG_ADDR_I == 16'h7F75
        && REG_WDATA_I[0]) |=> DMA_IRQ_O)
        else $error("interrupt flag dropped");
    eop_off_a: assert property (
        (DMA_TC_I == 4'h0) [*4] |-> ISA_EOP_N_O)
        else $error("end of process without count");
    eop_m2m_a: assert property (
        (DMA_TC_I != 4'h0 && DMA_MEM2MEM_I) [*4] |-> !ISA_EOP_N_O)
        else $error("count suppressed in mem-to-mem");
    mirror_a: assert property (
        REG_RD_I && REG_ADDR_I == 16'h7F73 && !$past(RESET_I)
        && !$past(RESET_I, 2)
        && $past(DMA_CH_STATUS_I) == DMA_CH_STATUS_I
        && $past(DMA_CH_STATUS_I, 2) == DMA_CH_STATUS_I
        |=> REG_RDATA_O == $past(DMA_CH_STATUS_I))
        else $error("mirror read differs from status");
    drain_a: assert property (
        $fell(BUS_GRANT_ACK_O)
        |-> DRAIN_BUSY_O ##[1:DMAX] !DRAIN_BUSY_O)
        else $error("drain busy wrong after ungrant");
endmodule
bind ibh_top ibh_top_asserts #(.DRAIN_CYC(DRAIN_CYC)) chk (
    .CLOCK_I(CLOCK_I), .RESET_I(RESET_I), .REG_ADDR_I(REG_ADDR_I),
    .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I),
    .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O),
    .DMA_CH_STATUS_I(DMA_CH_STATUS_I), .DMA_TC_I(DMA_TC_I),
    .DMA_MEM2MEM_I(DMA_MEM2MEM_I), .DMA_RESET_O(DMA_RESET_O),
    .BUS_GRANT_ACK_O(BUS_GRANT_ACK_O),
    .MCU_ISA_DRV_EN_O(MCU_ISA_DRV_EN_O), .ISA_EOP_N_O(ISA_EOP_N_O),
    .DMA_IRQ_O(DMA_IRQ_O), .DRAIN_BUSY_O(DRAIN_BUSY_O));

// ---- dv/ibh_dma_model.sv ----
// Behavioural DMA controller on the block's far side.
// Assumes the bench drives requests, counts and window reads.
`timescale 1ns/100ps
module ibh_dma_model (
    input  wire       clk_i,  // Clock
    input  wire       rst_i,  // Controller reset
    input  wire       gnt_i,  // Bus grant
    input  wire [3:0] req_i,  // Channel requests
    input  wire [3:0] tc_i,   // Count reached levels
    input  wire       clr_i,  // Status read via window
    output reg  [7:0] stat_o, // Channel status
    output wire       hold_o, // Hold request
    output reg        aen_o   // Address enable
);
    // Done bits set on count, cleared by a window read
    always @(posedge clk_i) begin
        if (rst_i) begin
            stat_o <= 8'h00;
            aen_o  <= 1'b0;
        end else begin
            stat_o[7:4] <= req_i;
            stat_o[3:0] <= clr_i ? 4'h0 : (stat_o[3:0] | tc_i);
            aen_o       <= gnt_i & hold_o;
        end
    end
    // Hold asked while any channel requests
    assign hold_o = |stat_o[7:4];
endmodule

// ---- dv/tb_isa_dma_bus_handoff_status.sv ----
// Self-checking bench for the DMA bus handoff block.
// Assumes the behavioural DMA model on the far side.
`timescale 1ns/100ps
`define CHK(n,e,g) begin num_checks++; if ((g) !== (e)) begin \
    error_cnt++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_isa_dma_bus_handoff_status;
    localparam DC = 4;  // Short drain count
    reg         clk, rst, wr, rd, clr, m2m;
    reg  [15:0] addr;
    reg  [7:0]  wd;
    reg  [3:0]  req, tc;
    wire [7:0]  rdata, st;
    wire        hold, aen, drst, gnt, drv, eop, irq, drn;
    integer     error_cnt, num_checks;
    ibh_top #(.DRAIN_CYC(DC)) uut (
        .CLOCK_I(clk), .RESET_I(rst), .REG_ADDR_I(addr),
        .REG_WDATA_I(wd), .REG_WR_I(wr), .REG_RD_I(rd),
        .REG_RDATA_O(rdata), .DMA_HOLD_REQ_I(hold), .DMA_AEN_I(aen),
        .DMA_CH_STATUS_I(st), .DMA_TC_I(tc), .DMA_MEM2MEM_I(m2m),
        .DMA_RESET_O(drst), .BUS_GRANT_ACK_O(gnt),
        .MCU_ISA_DRV_EN_O(drv), .ISA_EOP_N_O(eop), .DMA_IRQ_O(irq),
        .DRAIN_BUSY_O(drn));
    ibh_dma_model dma (.clk_i(clk), .rst_i(rst | drst), .gnt_i(gnt),
        .req_i(req), .tc_i(tc), .clr_i(clr), .stat_o(st),
        .hold_o(hold), .aen_o(aen));
    // Clock, 50 ns period
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Verdict and end of run
    task test_done;
        begin
            $display("checks %0d errors %0d", num_checks, error_cnt);
            if (error_cnt == 0 && num_checks > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    // One write strobe cycle
    task wrr(input [15:0] a, input [7:0] d);
        begin
            @(posedge clk);
            addr <= a;
            wd   <= d;
            wr   <= 1'b1;
            @(posedge clk);
            wr <= 1'b0;
            #1;
        end
    endtask
    // One read strobe cycle, data compared a cycle later
    task rc(input [15:0] a, input [7:0] e);
        begin
            @(posedge clk);
            addr <= a;
            rd   <= 1'b1;
            @(posedge clk);
            rd <= 1'b0;
            #1;
            `CHK("rdata", e, rdata)
        end
    endtask
    // Set controller levels, then let them cross
    task dm(input [3:0] r, input [3:0] t, input m);
        begin
            @(posedge clk);
            req <= r;
            tc  <= t;
            m2m <= m;
            repeat (6) @(posedge clk);
            #1;
        end
    endtask
    // Watchdog
    initial begin
        repeat (2000) @(posedge clk);
        error_cnt = error_cnt + 1;
        test_done;
    end
    // Main sequence
    initial begin
        error_cnt = 0;
        num_checks = 0;
        rst = 1'b1;
        {wr, rd, clr, m2m, addr, wd, req, tc} = 36'h0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rc(16'h7F70, 8'h00);
        rc(16'h7F74, 8'hFF);
        wrr(16'h7F7F, 8'hFF);
        rc(16'h7F7F, 8'h00);
        dm(4'h8, 4'h0, 1'b0);
        `CHK("irq", 1'b0, irq)
        rc(16'h7F73, 8'h80);
        rc(16'h7F70, 8'h01);
        wrr(16'h7F74, 8'h00);
        rc(16'h7F74, 8'h00);
        dm(4'h5, 4'h0, 1'b0);
        `CHK("irq", 1'b1, irq)
        wrr(16'h7F75, 8'h01);
        `CHK("irq", 1'b0, irq)
        dm(4'h5, 4'h2, 1'b0);
        `CHK("irq", 1'b1, irq)
        `CHK("eop", 1'b0, eop)
        rc(16'h7F73, 8'h52);
        rc(16'h7F73, 8'h52);
        @(posedge clk);
        #1;
        `CHK("rdidle", 8'h00, rdata)
        wrr(16'h7F70, 8'h20);
        dm(4'h5, 4'h2, 1'b0);
        `CHK("eop", 1'b1, eop)
        dm(4'h5, 4'h2, 1'b1);
        `CHK("eop", 1'b0, eop)
        // Window status read, count levels already gone, one wait state
        @(posedge clk);
        clr <= 1'b1;
        tc  <= 4'h0;
        repeat (2) @(posedge clk);
        clr <= 1'b0;
        dm(4'h5, 4'h0, 1'b0);
        rc(16'h7F73, 8'h50);
        wrr(16'h7F75, 8'h01);
        wrr(16'h7F70, 8'h02);
        `CHK("drv", 1'b0, drv)
        `CHK("gnt", 1'b1, gnt)
        dm(4'h5, 4'h0, 1'b0);
        rc(16'h7F70, 8'h07);
        `CHK("irq", 1'b0, irq)
        wrr(16'h7F70, 8'h00);
        `CHK("drain", 1'b1, drn)
        `CHK("drv", 1'b1, drv)
        rc(16'h7F75, 8'h02);
        repeat (DC + 2) @(posedge clk);
        #1;
        `CHK("drain", 1'b0, drn)
        wrr(16'h7F70, 8'h08);
        `CHK("dmarst", 1'b1, drst)
        dm(4'h5, 4'h0, 1'b0);
        rc(16'h7F73, 8'h00);
        test_done;
    end
endmodule
